// File: rtl/rspd_pkg.sv
package rspd_pkg;

  // Port geometry: D, E, F, G, I, J
  localparam int         NPORT = 6;
  localparam logic [2:0] PD = 3'd0;
  localparam logic [2:0] PE = 3'd1;
  localparam logic [2:0] PF = 3'd2;
  localparam logic [2:0] PG = 3'd3;
  localparam logic [2:0] PI = 3'd4;
  localparam logic [2:0] PJ = 3'd5;
  // Ports whose stop state comes from the alive registers
  localparam logic [5:0] ALIVE_MASK = 6'b111110;

  // Register map (byte addresses)
  localparam logic [9:0] PORT_LIMIT = 10'h0c0;
  localparam logic [2:0] REG_ALT    = 3'd0;
  localparam logic [2:0] REG_OUT    = 3'd1;
  localparam logic [2:0] REG_DIR    = 3'd2;
  localparam logic [2:0] REG_AOUT   = 3'd3;
  localparam logic [2:0] REG_ADIR   = 3'd4;
  localparam logic [2:0] REG_PIN    = 3'd5;
  localparam logic [9:0] OFF_STRAP  = 10'h100;
  localparam logic [9:0] OFF_MODE   = 10'h104;
  localparam logic [9:0] OFF_CTRL   = 10'h108;
  localparam int         CTRL_STOP  = 0;

  // Strap positions on port A pins
  localparam int A_NAND_BOOT = 14;
  localparam int A_NAND_SIZE = 13;
  localparam int A_NAND_W    = 12;
  localparam int A_NAND_CYC  = 11;
  localparam int A_SRAM0_W   = 10;
  localparam int A_SDR_TYPE  = 9;
  localparam int A_SDR_TOT   = 8;
  localparam int A_SDR_BW    = 6;
  localparam int A_SDR_CAP   = 4;
  localparam int A_SHADOW    = 3;
  localparam int A_UART_CLK  = 1;
  localparam int A_UART_BOOT = 0;
  // Strap positions on port B pins 15..13, stored as bits 2..0
  localparam int B_DEBUG     = 2;
  localparam int B_SRAM_BUF  = 1;
  localparam int B_NAND_BUF  = 0;
  // Test pins sit on port F bits 9..7
  localparam int F_TEST_LO   = 7;

  // Decoded values
  localparam logic [12:0] PAGE_2K   = 13'h0800;
  localparam logic [12:0] PAGE_4K   = 13'h1000;
  localparam logic [2:0]  CYC_3     = 3'h3;
  localparam logic [2:0]  CYC_4     = 3'h4;
  localparam logic [4:0]  PART_4    = 5'h04;
  localparam logic [4:0]  PART_8    = 5'h08;
  localparam logic [4:0]  PART_16   = 5'h10;
  localparam logic [9:0]  CAP_64    = 10'h040;
  localparam logic [9:0]  CAP_128   = 10'h080;
  localparam logic [9:0]  CAP_256   = 10'h100;
  localparam logic [9:0]  CAP_512   = 10'h200;

  // Reset values of the alternate-function registers
  localparam logic [15:0] ALT_D_RST  = 16'h0003;
  localparam logic [15:0] ALT_E_SRAM = 16'hff00;
  localparam logic [15:0] ALT_F_SRAM = 16'h03ff;
  localparam logic [15:0] ALT_G_SRAM = 16'hffff;

  // Bus handshake phases
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} rspd_bus_e;

  // Decoded boot configuration
  typedef struct packed {
    logic        nand_boot_en;
    logic [12:0] nand_page_bytes;
    logic        nand_bus_16;
    logic [2:0]  nand_addr_cycles;
    logic        sram0_bus_16;
    logic        sdram_type;
    logic        sdram_total_32;
    logic [4:0]  sdram_part_bits;
    logic [9:0]  sdram_cap_mbit;
    logic        sdram_shadow_en;
    logic        uart_clk_audio;
    logic        uart_boot_en;
    logic        cop_debug_en;
    logic        sram_buf_en;
    logic        nand_buf_en;
  } rspd_cfg_s;

  // Operating mode pins
  typedef struct packed {
    logic       test_mode;
    logic       fast_clk_ext;
    logic [2:0] test_pins;
  } rspd_mode_s;

endpackage

// File: rtl/rspd_top.sv
// Operation
// R1: Boot-size strap picks 2048 or 4096 byte page
// R2: NAND-width strap picks 8 or 16 bit
// R3: NAND-type strap picks 3 or 4 address cycles
// R4: SRAM-width strap picks bank zero 8/16 bit
// R5: Total-width strap picks SDRAM 16 or 32 bit
// R6: Part-width strap decodes 4, 8, 16 bit
// R7: Capacity strap decodes 64 to 512 Mbit
// R8: Boot-clock strap picks PLL or audio clock
// R9: UART download boot enabled when strap low
// R10: Coprocessor debug enabled when strap low
// R11: Test-enable high means test mode
// R12: Mode pin picks PLL or external core clock
// R13: Mode pins are test pins only in test
// R14: Other pins default to input after reset
// R15: Port D low pins default alternate
// R16: Port E upper alternate on SRAM 16-bit boot
// R17: Ports F, G alternate on SRAM boot
// R18: Alternate bit set selects alternate function
// R19: Stop mode follows alternate and output registers
// R20: Alive ports use alive registers in stop
// R21: Straps sampled in reset, held until next
// R22: Board holds straps through reset release
`timescale 1ns/1ns
module rspd_top
  import rspd_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst,
  // Avalon-MM slave
  // One wait state per access; 16-bit registers in the low half
  input  wire logic [9:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  // Strap and mode pins
  // Straps matter only while reset is high
  input  wire logic [15:0]             strap_port_a_in,
  input  wire logic [2:0]              strap_port_b_in,
  input  wire logic                    test_enable_in,
  input  wire logic                    core_clock_source_select,
  // Port pads
  // Index 0 to 5 is port D, E, F, G, I, J
  input  wire logic [5:0][15:0]        pad_in,
  output logic      [5:0][15:0]        pad_out,
  output logic      [5:0][15:0]        pad_oe,
  // Alternate function sources
  // Same clock as this block, so no synchroniser
  input  wire logic [5:0][15:0]        alt_out_in,
  input  wire logic [5:0][15:0]        alt_oe_in,
  // Configuration to the chip
  // boot_cfg held from reset release until the next reset; op_mode follows the mode pins and stop_mode the stop bit
  output rspd_cfg_s                    boot_cfg,
  output rspd_mode_s                   op_mode,
  output logic                         stop_mode
);

  // Whole module state
  typedef struct packed {
    // Strap synchronisers, port A then port B
    logic [15:0]       a1;
    logic [15:0]       a2;
    logic [2:0]        b1;
    logic [2:0]        b2;
    // Mode pin synchronisers: bit 0 test enable, bit 1 clock source
    logic [1:0]        m1;
    logic [1:0]        m2;
    // Pad level synchronisers, read back through the pin register
    logic [5:0][15:0]  p1;
    logic [5:0][15:0]  p2;
    // Raw straps as captured during reset
    logic [15:0]       strap_a;
    logic [2:0]        strap_b;
    // Decoded configuration and live mode levels
    rspd_cfg_s         cfg;
    rspd_mode_s        mode;
    // Port registers seen by software
    logic [5:0][15:0]  alt;
    logic [5:0][15:0]  outv;
    logic [5:0][15:0]  dir;
    logic [5:0][15:0]  aout;
    logic [5:0][15:0]  adir;
    // Stop-mode control bit
    logic              stop;
    // Registered pad drive
    logic [5:0][15:0]  pout;
    logic [5:0][15:0]  poe;
    // Register bus handshake
    rspd_bus_e         bus;
    logic              wait_r;
    logic [31:0]       rdata;
  } rspd_state_s;

  rspd_state_s s_r;    // Registered state
  rspd_state_s s_nxt;  // Next state

  // Decode the captured straps into the configuration
  function automatic rspd_cfg_s cfg_decode(input logic [15:0] a, input logic [2:0] b);
    rspd_cfg_s c;
    // Start from zero so no field is left unknown
    c = '0;
    // Boot source: low selects static memory boot
    c.nand_boot_en     = a[A_NAND_BOOT];
    // R1: page size select
    c.nand_page_bytes  = a[A_NAND_SIZE] ? PAGE_4K : PAGE_2K;
    // R2: NAND bus width
    c.nand_bus_16      = a[A_NAND_W];
    // R3: address cycle count
    c.nand_addr_cycles = a[A_NAND_CYC] ? CYC_4 : CYC_3;
    // R4: SRAM bank zero width
    c.sram0_bus_16     = a[A_SRAM0_W];
    // SDRAM pull style passes straight through
    c.sdram_type       = a[A_SDR_TYPE];
    // R5: SDRAM total width
    c.sdram_total_32   = a[A_SDR_TOT];
    // Code 3 is undefined and gives zero width
    // R6: SDRAM part width
    case (a[A_SDR_BW+:2])
      2'h0:    c.sdram_part_bits = PART_4;
      2'h1:    c.sdram_part_bits = PART_8;
      2'h2:    c.sdram_part_bits = PART_16;
      default: c.sdram_part_bits = 5'h00;  // Undefined code
    endcase
    // All four capacity codes are defined
    // R7: SDRAM capacity
    case (a[A_SDR_CAP+:2])
      2'h0:    c.sdram_cap_mbit = CAP_64;
      2'h1:    c.sdram_cap_mbit = CAP_128;
      2'h2:    c.sdram_cap_mbit = CAP_256;
      default: c.sdram_cap_mbit = CAP_512;
    endcase
    // Shadow enable passes straight through
    c.sdram_shadow_en  = a[A_SHADOW];
    // R8: boot-loader clock source
    c.uart_clk_audio   = a[A_UART_CLK];
    // R9: active-low download enable
    c.uart_boot_en     = ~a[A_UART_BOOT];
    // R10: active-low debug enable
    c.cop_debug_en     = ~b[B_DEBUG];
    // Buffer enables on port B pass through
    c.sram_buf_en      = b[B_SRAM_BUF];
    c.nand_buf_en      = b[B_NAND_BUF];
    return c;
  endfunction

  // Merge write data into a 16-bit register by byte lanes
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    // Lanes not enabled keep their old value
    r = old;
    // Lane 0 feeds the low byte
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    // Lane 1 feeds the high byte; lanes 2 and 3 have no storage
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Read multiplexer over the whole map
  function automatic logic [31:0] rd_word(input rspd_state_s s, input logic [9:0] addr);
    logic [2:0]  pi;
    logic [2:0]  ri;
    logic [31:0] r;
    // Port index and register index within the port block
    pi = addr[7:5];
    ri = addr[4:2];
    // Anything not decoded below reads as zero
    r  = '0;
    if (addr < PORT_LIMIT && addr[1:0] == 2'h0) begin
      // Word-aligned access inside the port blocks
      case (ri)
        REG_ALT:  r = {16'h0000, s.alt[pi]};
        REG_OUT:  r = {16'h0000, s.outv[pi]};
        REG_DIR:  r = {16'h0000, s.dir[pi]};
        REG_AOUT: r = {16'h0000, s.aout[pi]};
        REG_ADIR: r = {16'h0000, s.adir[pi]};
        // Pin register shows the synchronised pad level
        REG_PIN:  r = {16'h0000, s.p2[pi]};
        default:  r = '0;  // Hole in the port block
      endcase
    end else if (addr == OFF_STRAP) begin
      // Captured straps, port B above port A
      r = {13'h0000, s.strap_b, s.strap_a};
    end else if (addr == OFF_MODE) begin
      // Live mode levels
      r = {27'h0000000, s.mode};
    end else if (addr == OFF_CTRL) begin
      // Stop-mode control
      r = {31'h00000000, s.stop};
    end
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    // Port and register index of the current access
    logic [2:0]  pi;
    logic [2:0]  ri;
    // High when the boot strap selects static memory
    logic        sram_boot;
    pi        = avs_address[7:5];
    ri        = avs_address[4:2];
    sram_boot = 1'b0;
    // Hold everything unless a branch below changes it
    s_nxt     = s_r;
    // Two-stage synchronisers for every pin input
    // Only the second stage of each pair feeds logic
    s_nxt.a1 = strap_port_a_in;
    s_nxt.a2 = s_r.a1;
    s_nxt.b1 = strap_port_b_in;
    s_nxt.b2 = s_r.b1;
    s_nxt.m1 = {core_clock_source_select, test_enable_in};
    s_nxt.m2 = s_r.m1;
    s_nxt.p1 = pad_in;
    s_nxt.p2 = s_r.p1;
    // Mode levels follow the pins in reset and in run
    // R11: test mode follows test enable
    s_nxt.mode.test_mode = s_r.m2[0];
    // R12: core clock source select
    s_nxt.mode.fast_clk_ext = s_r.m2[1];
    // R13: mode pins valid only in test
    s_nxt.mode.test_pins = s_r.m2[0] ? s_r.p2[PF][F_TEST_LO+:3] : 3'h0;
    if (rst) begin
      // R21: sample straps during reset
      s_nxt.strap_a = s_r.a2;
      s_nxt.strap_b = s_r.b2;
      s_nxt.cfg     = cfg_decode(s_r.a2, s_r.b2);
      sram_boot     = ~s_r.a2[A_NAND_BOOT];
      // R14: everything else starts as input
      s_nxt.alt  = '0;
      s_nxt.outv = '0;
      s_nxt.dir  = '0;
      // Alive registers start cleared as well
      s_nxt.aout = '0;
      s_nxt.adir = '0;
      // R15: port D low pins alternate
      s_nxt.alt[PD] = ALT_D_RST;
      // R16: port E upper byte alternate
      if (sram_boot && s_r.a2[A_SRAM0_W]) begin
        s_nxt.alt[PE] = ALT_E_SRAM;
      end
      // R17: address ports alternate
      if (sram_boot) begin
        s_nxt.alt[PF] = ALT_F_SRAM;
        s_nxt.alt[PG] = ALT_G_SRAM;
      end
      // Bus, stop control and pads start idle and undriven
      s_nxt.stop   = 1'b0;
      s_nxt.pout   = '0;
      s_nxt.poe    = '0;
      s_nxt.bus    = BUS_IDLE;
      s_nxt.wait_r = 1'b1;
      s_nxt.rdata  = '0;
    end else begin
      // Bus handshake: one wait cycle, then answer
      case (s_r.bus)
        BUS_IDLE: begin
          // Wait for a request and answer in the next cycle
          s_nxt.wait_r = 1'b1;
          if (avs_read || avs_write) begin
            // Read data is latched now so it stands with the answer
            s_nxt.bus    = BUS_ACK;
            s_nxt.wait_r = 1'b0;
            s_nxt.rdata  = avs_read ? rd_word(s_r, avs_address) : 32'h00000000;
          end
        end
        BUS_ACK: begin
          // Write lands on the edge that sees waitrequest low
          // The master releases its request after this edge
          s_nxt.bus    = BUS_IDLE;
          s_nxt.wait_r = 1'b1;
          if (avs_write) begin
            if (avs_address < PORT_LIMIT && avs_address[1:0] == 2'h0) begin
              // Port registers take only lanes 0 and 1
              case (ri)
                REG_ALT:  s_nxt.alt[pi]  = be_merge(s_r.alt[pi], avs_writedata, avs_byteenable);
                REG_OUT:  s_nxt.outv[pi] = be_merge(s_r.outv[pi], avs_writedata, avs_byteenable);
                REG_DIR:  s_nxt.dir[pi]  = be_merge(s_r.dir[pi], avs_writedata, avs_byteenable);
                REG_AOUT: s_nxt.aout[pi] = be_merge(s_r.aout[pi], avs_writedata, avs_byteenable);
                REG_ADIR: s_nxt.adir[pi] = be_merge(s_r.adir[pi], avs_writedata, avs_byteenable);
                default:  s_nxt.bus      = BUS_IDLE;  // Pin readback is read-only
              endcase
            end else if (avs_address == OFF_CTRL && avs_byteenable[0]) begin
              // Stop bit lives in lane 0
              s_nxt.stop = avs_writedata[CTRL_STOP];
            end
          end
        end
        default: begin
          // Illegal encoding falls back to idle
          s_nxt.bus    = BUS_IDLE;
          s_nxt.wait_r = 1'b1;
        end
      endcase
      // Pad drive per port
      // Each port picks alive or register drive as a whole 16-bit group
      for (int i = 0; i < NPORT; i++) begin
        if (s_r.stop && ALIVE_MASK[i]) begin
          // Port D is not alive and never takes this branch
          // R20: alive registers own these pads in stop
          s_nxt.pout[i] = s_r.aout[i];
          s_nxt.poe[i]  = s_r.adir[i];
        end else begin
          // Outside stop the alive registers have no effect
          // R18: alternate bit steers the pad
          // R19: stop mode keeps register-driven state
          s_nxt.pout[i] = (s_r.alt[i] & alt_out_in[i]) | (~s_r.alt[i] & s_r.outv[i]);
          s_nxt.poe[i]  = (s_r.alt[i] & alt_oe_in[i]) | (~s_r.alt[i] & s_r.dir[i]);
        end
      end
      // Leaves the board free to drive the test pins
      // R13: test pins are never driven in test mode
      if (s_r.m2[0]) begin
        s_nxt.poe[PF][F_TEST_LO+:3] = 3'h0;
      end
    end
  end

  // State register
  // Reset is handled in the next-state logic
  always_ff @(posedge clock) begin
    s_r <= s_nxt;
  end

  // Outputs straight from the state register
  // No logic sits between the register and a port
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = s_r.wait_r;
  assign pad_out         = s_r.pout;
  assign pad_oe          = s_r.poe;
  assign boot_cfg        = s_r.cfg;
  assign op_mode         = s_r.mode;
  assign stop_mode       = s_r.stop;

endmodule

// File: sim/rspd_top_monitor.sv
`timescale 1ns/1ns
module rspd_top_monitor
  import rspd_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst,
  // Register bus
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // Pins and configuration
  input wire logic [5:0][15:0] pad_oe,
  input wire logic             test_enable_in,
  input wire logic             core_clock_source_select,
  input wire rspd_cfg_s        boot_cfg,
  input wire rspd_mode_s       op_mode
);
  // Cycles since reset release, saturating so history is clean
  logic [2:0] up_r;
  // Count up after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      up_r <= 3'h0;
    end else if (up_r != 3'h7) begin
      up_r <= up_r + 3'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:19] == 13'h0)
    else $error("upper read bits set");
  a_reset_quiet: assert property ($fell(rst) |-> pad_oe == '0 && avs_waitrequest)
    else $error("pads driven after reset");
  a_cfg_held: assert property (up_r == 3'h7 |-> $stable(boot_cfg))
    else $error("boot config changed");
  a_test_follow: assert property (up_r == 3'h7 |-> op_mode.test_mode == $past(test_enable_in, 3))
    else $error("test mode wrong");
  a_clk_follow: assert property (up_r == 3'h7 |-> op_mode.fast_clk_ext == $past(core_clock_source_select, 3))
    else $error("clock source wrong");
  a_test_pins_off: assert property (op_mode.test_mode && $past(op_mode.test_mode) |-> pad_oe[2][9:7] == 3'h0)
    else $error("test pins driven");
endmodule
bind rspd_top rspd_top_monitor u_mon (.clock(clock), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_oe(pad_oe),
  .test_enable_in(test_enable_in), .core_clock_source_select(core_clock_source_select),
  .boot_cfg(boot_cfg), .op_mode(op_mode));

// File: sim/rspd_board.sv
`timescale 1ns/1ns
module rspd_board
  import rspd_pkg::*;
(
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst,
  // Chosen strap pattern and board pin levels
  input wire logic [15:0]      pat_a,
  input wire logic [2:0]       pat_b,
  input wire logic [5:0][15:0] ext_lvl,
  // Device pads
  input wire logic [5:0][15:0] pad_out,
  input wire logic [5:0][15:0] pad_oe,
  output logic     [15:0]      strap_a,
  output logic     [2:0]       strap_b,
  output logic     [5:0][15:0] pad_in
);
  // Cycles since reset release
  logic [3:0] hold_r;
  // Count up after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_r <= 4'h0;
    end else if (hold_r != 4'hf) begin
      hold_r <= hold_r + 4'h1;
    end
  end
  assign strap_a = (rst || hold_r < 4'h4) ? pat_a : ~pat_a;
  assign strap_b = (rst || hold_r < 4'h4) ? pat_b : ~pat_b;
  // Pad level: device drive, else board level
  assign pad_in = (pad_out & pad_oe) | (ext_lvl & ~pad_oe);
endmodule

// File: sim/test_rspd_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_rspd_top
  import rspd_pkg::*;
;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, te, cs, stop_mode;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0] avs_byteenable;
  logic [15:0] pat_a, strap_a, a, eo, ev;
  logic [2:0] pat_b, strap_b, b;
  logic [5:0][15:0] pad_in, pad_out, pad_oe, aout, aoe, ext_lvl;
  rspd_cfg_s boot_cfg;
  rspd_mode_s op_mode;
  int err_total, compares, cyc;
  logic [4:0] parts [4] = '{PART_4, PART_8, PART_16, 5'h00};
  logic [9:0] caps [4] = '{CAP_64, CAP_128, CAP_256, CAP_512};
  rspd_top dut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .strap_port_a_in(strap_a),
    .strap_port_b_in(strap_b), .test_enable_in(te), .core_clock_source_select(cs), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .alt_out_in(aout), .alt_oe_in(aoe), .boot_cfg(boot_cfg),
    .op_mode(op_mode), .stop_mode(stop_mode));
  rspd_board board (.clock(clock), .rst(rst), .pat_a(pat_a), .pat_b(pat_b), .ext_lvl(ext_lvl),
    .pad_out(pad_out), .pad_oe(pad_oe), .strap_a(strap_a), .strap_b(strap_b), .pad_in(pad_in));
  // Clock of 40 ns
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run;
    end
  end
  // Bus read, holds until waitrequest is seen low
  task automatic bus_rd(input logic [9:0] ad, output logic [31:0] rd);
    @(posedge clock);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Bus write, holds until waitrequest is seen low
  task automatic bus_wr(input logic [9:0] ad, input logic [31:0] wd, input logic [3:0] be);
    @(posedge clock);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h000; avs_writedata = 32'h0;
    avs_byteenable = 4'h3; te = 1'b0; cs = 1'b0; pat_a = 16'h0000; pat_b = 3'h0;
    aout = {6{16'h5a5a}}; aoe = {6{16'h0f0f}}; ext_lvl = {6{16'hffff}};
    err_total = 0; compares = 0; cyc = 0;
    // Strap patterns, one reset each
    for (int k = 0; k < 4; k++) begin
      a = (k[0] ? 16'h7b0b : 16'h0000) | (k[1] ? 16'h0400 : 16'h0000) | 16'(k << 6) | 16'(k << 4);
      b = {k[0], k[1], k[0]};
      @(posedge clock);
      rst <= 1'b1;
      pat_a <= a;
      pat_b <= b;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (8) @(posedge clock);
      `CHK("page", a[13] ? PAGE_4K : PAGE_2K, boot_cfg.nand_page_bytes)
      `CHK("nand16", a[12], boot_cfg.nand_bus_16)
      `CHK("cycles", a[11] ? CYC_4 : CYC_3, boot_cfg.nand_addr_cycles)
      `CHK("sram16", a[10], boot_cfg.sram0_bus_16)
      `CHK("total32", a[8], boot_cfg.sdram_total_32)
      `CHK("part", parts[k], boot_cfg.sdram_part_bits)
      `CHK("cap", caps[k], boot_cfg.sdram_cap_mbit)
      `CHK("uclk", a[1], boot_cfg.uart_clk_audio)
      `CHK("uboot", ~a[0], boot_cfg.uart_boot_en)
      `CHK("dbg", ~b[2], boot_cfg.cop_debug_en)
      `CHK("nboot", a[14], boot_cfg.nand_boot_en)
      `CHK("sdtype", a[9], boot_cfg.sdram_type)
      `CHK("shadow", a[3], boot_cfg.sdram_shadow_en)
      `CHK("srbuf", b[1], boot_cfg.sram_buf_en)
      `CHK("nfbuf", b[0], boot_cfg.nand_buf_en)
      bus_rd(OFF_STRAP, d);
      `CHK("straps", {13'h0, b, a}, d)
      for (int p = 0; p < 6; p++) begin
        ev = (p == 0) ? ALT_D_RST : (p == 1 && !a[14] && a[10]) ? ALT_E_SRAM :
             (p == 2 && !a[14]) ? ALT_F_SRAM : (p == 3 && !a[14]) ? ALT_G_SRAM : 16'h0000;
        bus_rd(10'(p * 32), d);
        `CHK("alt", {16'h0000, ev}, d)
        bus_rd(10'(p * 32 + 8), d);
        `CHK("dir", 32'h0, d)
      end
    end
    // Port F drives its test pins low until test mode releases them
    bus_wr(10'h048, 32'h0380, 4'h3);
    // Mode pins in every combination
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      te <= k[0];
      cs <= k[1];
      ext_lvl[2][9:7] <= 3'(k + 3);
      repeat (8) @(posedge clock);
      `CHK("test", k[0], op_mode.test_mode)
      `CHK("fast_core_clock", k[1], op_mode.fast_clk_ext)
      `CHK("tpins", k[0] ? 3'(k + 3) : 3'h0, op_mode.test_pins)
      bus_rd(OFF_MODE, d);
      `CHK("mode", {27'h0, k[0], k[1], k[0] ? 3'(k + 3) : 3'h0}, d)
    end
    te <= 1'b0;
    // Port D: alternate bits choose alternate drive, byte lane 0 only
    bus_wr(10'h004, 32'h1234, 4'h3);
    bus_wr(10'h008, 32'h0ff0, 4'h3);
    bus_wr(10'h000, 32'h000f, 4'h3);
    bus_wr(10'h004, 32'hffff, 4'h1);
    bus_wr(10'h014, 32'h0000, 4'h3);
    repeat (4) @(posedge clock);
    eo = 16'h0fff;
    ev = ((16'h000f & 16'h5a5a) | (16'hfff0 & 16'h12ff)) & eo;
    `CHK("d_oe", eo, pad_oe[0])
    `CHK("d_out", ev, pad_out[0] & eo)
    bus_rd(10'h014, d);
    `CHK("d_pin", {16'h0, ev | ~eo}, d)
    bus_rd(10'h0c0, d);
    `CHK("unmapped", 32'h0, d)
    // Stop mode: port E from alive registers, port D unchanged
    bus_wr(10'h02c, 32'h00a5, 4'h3);
    bus_wr(10'h030, 32'h00ff, 4'h3);
    bus_wr(OFF_CTRL, 32'h1, 4'h3);
    repeat (3) @(posedge clock);
    `CHK("stop", 1'b1, stop_mode)
    `CHK("e_oe", 16'h00ff, pad_oe[1])
    `CHK("e_out", 16'h00a5, pad_out[1] & 16'h00ff)
    `CHK("d_stop", eo, pad_oe[0])
    bus_wr(OFF_CTRL, 32'h0, 4'h3);
    complete_run;
  end
endmodule
